// >>> pkg/pes_async_if.sv
// carrier for synchronised external event levels between sequencer modules
`timescale 1ns/1ps
interface pes_async_if;
    logic [3:0] lvl;  // 0 ext, 1 dec, 2 smi, 3 perfmon
    logic       mchk;
    logic       sreset;
    modport src (output lvl, output mchk, output sreset);
    modport dst (input lvl, input mchk, input sreset);
endinterface

// >>> pkg/pes_defines.svh
// constants for the exception sequencer: vectors, state bit positions, timing
`ifndef PES_DEFINES_SVH
`define PES_DEFINES_SVH

`define PES_VEC_RESET      20'h00100
`define PES_VEC_MCHECK     20'h00200
`define PES_VEC_DSI        20'h00300
`define PES_VEC_ISI        20'h00400
`define PES_VEC_EXT        20'h00500
`define PES_VEC_ALIGN      20'h00600
`define PES_VEC_PROGRAM    20'h00700
`define PES_VEC_FPUNAVAIL  20'h00800
`define PES_VEC_DEC        20'h00900
`define PES_VEC_SYSCALL    20'h00c00
`define PES_VEC_TRACE      20'h00d00
`define PES_VEC_PERFMON    20'h00f00
`define PES_VEC_SMI        20'h01400

`define PES_MST_EE         15
`define PES_MST_PR         14
`define PES_MST_MCE        12
`define PES_MST_REC        1
`define PES_MST_RESET      32'h0000_0000
`define PES_MST_KEEP_MASK  32'h0000_1000

`define PES_NSYNC          8
`endif

// >>> pkg/pes_pkg.sv
// types shared by the precise exception sequencer modules
package pes_pkg;
    typedef enum logic [3:0] {
        PES_EXC_NONE,
        PES_EXC_RESET,
        PES_EXC_MCHECK,
        PES_EXC_DSI,
        PES_EXC_ISI,
        PES_EXC_EXT,
        PES_EXC_ALIGN,
        PES_EXC_PROGRAM,
        PES_EXC_FPUNAVAIL,
        PES_EXC_DEC,
        PES_EXC_SYSCALL,
        PES_EXC_TRACE,
        PES_EXC_PERFMON,
        PES_EXC_SMI
    } pes_exc_t;

    typedef enum logic [1:0] {
        PES_CLS_SYNC_PRECISE,
        PES_CLS_SYNC_IMPRECISE,
        PES_CLS_ASYNC_MASKABLE,
        PES_CLS_ASYNC_NONMASKABLE
    } pes_cls_t;
endpackage

// >>> src/pes_pin_sync.sv
// two-flop synchronisers for the asynchronous event pins
`timescale 1ns/1ps
module pes_pin_sync
    import pes_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic [5:0] pins_i,
    pes_async_if.src        evt
);
    logic [5:0] meta;
    logic [5:0] sync;

    // second flop alone reads the first, keeping metastability off the logic
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_sync
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta[g] <= 1'b0;
                    sync[g] <= 1'b0;
                end else begin
                    meta[g] <= pins_i[g];
                    sync[g] <= meta[g];
                end
            end
        end
    endgenerate

    assign evt.lvl    = sync[3:0];
    assign evt.mchk   = sync[4];
    assign evt.sreset = sync[5];
endmodule

// >>> src/pes_sequencer.sv
// precise exception sequencer: classification, ordering, context save and vectoring
// Operation
// - conditions may be seen out of order but are taken in program order
// - all older instructions complete before an instruction-caused exception is taken
// - several conditions of one instruction are taken one after another
// - asynchronous precise events wait until the execute stage has drained
// - taking saves address and state, and redirects fetch to the type vector
// - taking switches to supervisor privilege for the handler
// - external events are asynchronous, instruction events synchronous
// - ext, dec, smi, perfmon maskable; machine check and reset nonmaskable
// - only floating-point imprecise is synchronous imprecise; others precise
// - shared vectors record the specific cause in its status register
// - soft or hard reset vectors to offset 00100
// - qualified tea or mcheck input vectors to 00200, or checkstop when enable clear
// - taking any exception clears the machine check enable bit
`timescale 1ns/1ps
`include "pes_defines.svh"
module pes_sequencer
    import pes_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        soft_reset_i,
    input  wire logic        hard_reset_i,
    input  wire logic        ext_int_i,
    input  wire logic        dec_int_i,
    input  wire logic        smi_int_i,
    input  wire logic        perfmon_i,
    input  wire logic        machine_check_input_i,
    input  wire logic        transfer_error_ack_i,
    input  wire logic        tea_qualify_i,
    input  wire logic        oldest_valid_i,
    input  wire logic [31:0] oldest_pc_i,
    input  wire logic [11:0] oldest_exc_i,
    input  wire logic        fp_imprecise_i,
    input  wire logic [31:0] dsi_cause_i,
    input  wire logic [31:0] fp_cause_i,
    input  wire logic        older_pending_i,
    input  wire logic        exec_busy_i,
    input  wire logic [31:0] next_pc_i,
    input  wire logic        rfi_i,
    input  wire logic        state_corrupt_i,
    output logic             flush_o,
    output logic             fetch_redirect_o,
    output logic [31:0]      fetch_addr_o,
    output logic [31:0]      save_restore_addr_reg_o,
    output logic [31:0]      save_restore_state_reg_o,
    output logic [31:0]      machine_state_reg_o,
    output logic [31:0]      storage_fault_cause_reg_o,
    output logic [31:0]      float_status_control_reg_o,
    output logic [3:0]       exc_type_o,
    output logic [1:0]       exc_class_o,
    output logic             checkstop_o,
    output logic             hold_dispatch_o,
    output logic             retire_block_o
);
    ////////////////////////////////////////////////////////////////////////////
    // synchronised external events
    pes_async_if evt ();
    logic        hard_sync_meta;
    logic        hard_sync;

    pes_pin_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pins_i    ({soft_reset_i, machine_check_input_i, perfmon_i, smi_int_i,
                     dec_int_i, ext_int_i}),
        .evt       (evt)
    );

    // hard reset also passes two flops; the async rstn_i only clears state
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hard_sync_meta <= 1'b0;
            hard_sync      <= 1'b0;
        end else begin
            hard_sync_meta <= hard_reset_i;
            hard_sync      <= hard_sync_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer state
    typedef enum logic [1:0] {PES_ST_RUN, PES_ST_DRAIN, PES_ST_TAKE, PES_ST_STOP} pes_st_t;
    pes_st_t     state;
    pes_exc_t    pend_exc;
    logic [11:0] done_mask;   // conditions of the oldest instruction already taken
    logic [31:0] pend_pc;
    logic        tea_lvl;

    // qualified transfer error is a same-clock bus indication; hold it until taken
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tea_lvl <= 1'b0;
        end else if (transfer_error_ack_i && tea_qualify_i) begin
            tea_lvl <= 1'b1;  // set wins over clear
        end else if (state == PES_ST_TAKE && pend_exc == PES_EXC_MCHECK) begin
            tea_lvl <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // priority selection
    logic        mce;
    logic        ee;
    logic [11:0] sync_open;
    pes_exc_t    next_exc;
    logic        next_async;
    logic        mchk_req;

    assign mce       = machine_state_reg_o[`PES_MST_MCE];
    assign ee        = machine_state_reg_o[`PES_MST_EE];
    assign sync_open = oldest_exc_i & ~done_mask;
    assign mchk_req  = evt.mchk | tea_lvl;

    // sync bit order: 0 isi,1 dsi,2 align,3 program,4 fpunavail,5 syscall,6 trace
    always_comb begin
        next_exc   = PES_EXC_NONE;
        next_async = 1'b0;
        if (evt.sreset || hard_sync) begin
            next_exc   = PES_EXC_RESET;
            next_async = 1'b1;
        end else if (mchk_req) begin
            next_exc   = PES_EXC_MCHECK;
            next_async = 1'b1;
        end else if (oldest_valid_i && sync_open[0]) begin
            next_exc = PES_EXC_ISI;
        end else if (oldest_valid_i && sync_open[1]) begin
            next_exc = PES_EXC_DSI;
        end else if (oldest_valid_i && sync_open[2]) begin
            next_exc = PES_EXC_ALIGN;
        end else if (oldest_valid_i && (sync_open[3] || fp_imprecise_i)) begin
            next_exc = PES_EXC_PROGRAM;
        end else if (oldest_valid_i && sync_open[4]) begin
            next_exc = PES_EXC_FPUNAVAIL;
        end else if (oldest_valid_i && sync_open[5]) begin
            next_exc = PES_EXC_SYSCALL;
        end else if (oldest_valid_i && sync_open[6]) begin
            next_exc = PES_EXC_TRACE;
        end else if (ee && evt.lvl[0]) begin
            next_exc   = PES_EXC_EXT;
            next_async = 1'b1;
        end else if (ee && evt.lvl[1]) begin
            next_exc   = PES_EXC_DEC;
            next_async = 1'b1;
        end else if (ee && evt.lvl[2]) begin
            next_exc   = PES_EXC_SMI;
            next_async = 1'b1;
        end else if (ee && evt.lvl[3]) begin
            next_exc   = PES_EXC_PERFMON;
            next_async = 1'b1;
        end
    end

    function automatic logic [19:0] pes_vector(input pes_exc_t e);
        case (e)
            PES_EXC_RESET:     pes_vector = `PES_VEC_RESET;
            PES_EXC_MCHECK:    pes_vector = `PES_VEC_MCHECK;
            PES_EXC_DSI:       pes_vector = `PES_VEC_DSI;
            PES_EXC_ISI:       pes_vector = `PES_VEC_ISI;
            PES_EXC_EXT:       pes_vector = `PES_VEC_EXT;
            PES_EXC_ALIGN:     pes_vector = `PES_VEC_ALIGN;
            PES_EXC_PROGRAM:   pes_vector = `PES_VEC_PROGRAM;
            PES_EXC_FPUNAVAIL: pes_vector = `PES_VEC_FPUNAVAIL;
            PES_EXC_DEC:       pes_vector = `PES_VEC_DEC;
            PES_EXC_SYSCALL:   pes_vector = `PES_VEC_SYSCALL;
            PES_EXC_TRACE:     pes_vector = `PES_VEC_TRACE;
            PES_EXC_PERFMON:   pes_vector = `PES_VEC_PERFMON;
            PES_EXC_SMI:       pes_vector = `PES_VEC_SMI;
            default:           pes_vector = 20'h00000;
        endcase
    endfunction

    function automatic pes_cls_t pes_class(input pes_exc_t e, input logic fpi);
        case (e)
            PES_EXC_RESET, PES_EXC_MCHECK:
                pes_class = PES_CLS_ASYNC_NONMASKABLE;
            PES_EXC_EXT, PES_EXC_DEC, PES_EXC_SMI, PES_EXC_PERFMON:
                pes_class = PES_CLS_ASYNC_MASKABLE;
            default:
                pes_class = fpi ? PES_CLS_SYNC_IMPRECISE : PES_CLS_SYNC_PRECISE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state machine: run, drain older work, take, or checkstop
    logic drained;
    assign drained = !older_pending_i && !exec_busy_i;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state     <= PES_ST_RUN;
            pend_exc  <= PES_EXC_NONE;
            pend_pc   <= 32'h0000_0000;
        end else begin
            case (state)
                PES_ST_RUN: begin
                    if (next_exc == PES_EXC_MCHECK && !mce) begin
                        state <= PES_ST_STOP;
                    end else if (next_exc != PES_EXC_NONE) begin
                        pend_exc  <= next_exc;
                        pend_pc   <= next_async ? next_pc_i : oldest_pc_i;
                        // reset acts at once; everything else drains first
                        state <= (next_exc == PES_EXC_RESET) ? PES_ST_TAKE : PES_ST_DRAIN;
                    end
                end
                PES_ST_DRAIN: begin
                    if (next_exc == PES_EXC_RESET) begin
                        pend_exc <= PES_EXC_RESET;  // reset preempts the wait
                        state    <= PES_ST_TAKE;
                    end else if (drained) begin
                        state <= PES_ST_TAKE;
                    end
                end
                PES_ST_TAKE: begin
                    state <= PES_ST_RUN;
                end
                PES_ST_STOP: begin
                    if (evt.sreset || hard_sync) begin
                        pend_exc <= PES_EXC_RESET;
                        state    <= PES_ST_TAKE;
                    end
                end
                default: state <= PES_ST_RUN;
            endcase
        end
    end

    // remember which conditions of the oldest instruction were taken
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_mask <= 12'h000;
        end else if (!oldest_valid_i || oldest_exc_i == 12'h000) begin
            done_mask <= 12'h000;
        end else if (state == PES_ST_TAKE) begin
            case (pend_exc)
                PES_EXC_ISI:       done_mask[0] <= 1'b1;
                PES_EXC_DSI:       done_mask[1] <= 1'b1;
                PES_EXC_ALIGN:     done_mask[2] <= 1'b1;
                PES_EXC_PROGRAM:   done_mask[3] <= 1'b1;
                PES_EXC_FPUNAVAIL: done_mask[4] <= 1'b1;
                PES_EXC_SYSCALL:   done_mask[5] <= 1'b1;
                PES_EXC_TRACE:     done_mask[6] <= 1'b1;
                default:           done_mask <= done_mask;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // context save, state word update and fetch redirect
    logic [31:0] next_mst;
    always_comb begin
        next_mst = machine_state_reg_o & `PES_MST_KEEP_MASK;
        next_mst[`PES_MST_PR] = 1'b0;
        next_mst[`PES_MST_EE] = 1'b0;
        next_mst[`PES_MST_MCE] = 1'b0;
        next_mst[`PES_MST_REC] = 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            machine_state_reg_o      <= `PES_MST_RESET;
            save_restore_addr_reg_o  <= 32'h0000_0000;
            save_restore_state_reg_o <= 32'h0000_0000;
            fetch_redirect_o         <= 1'b0;
            fetch_addr_o             <= 32'h0000_0000;
            exc_type_o               <= 4'h0;
            exc_class_o              <= 2'h0;
            flush_o                  <= 1'b0;
        end else begin
            fetch_redirect_o <= 1'b0;
            flush_o          <= 1'b0;
            if (state == PES_ST_TAKE) begin
                save_restore_addr_reg_o  <= pend_pc;
                save_restore_state_reg_o <= machine_state_reg_o;
                if (state_corrupt_i || pend_exc == PES_EXC_RESET) begin
                    save_restore_state_reg_o[`PES_MST_REC] <= 1'b0;
                end
                machine_state_reg_o <= next_mst;
                fetch_addr_o        <= {12'h000, pes_vector(pend_exc)};
                fetch_redirect_o    <= 1'b1;
                flush_o             <= 1'b1;
                exc_type_o          <= pend_exc;
                // only a program take may be imprecise; other types stay precise
                exc_class_o <= pes_class(pend_exc, fp_imprecise_i && pend_exc == PES_EXC_PROGRAM);
            end else if (rfi_i) begin
                machine_state_reg_o <= save_restore_state_reg_o;
            end
        end
    end

    // specific cause recording for shared vectors
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            storage_fault_cause_reg_o  <= 32'h0000_0000;
            float_status_control_reg_o <= 32'h0000_0000;
        end else if (state == PES_ST_TAKE) begin
            if (pend_exc == PES_EXC_DSI || pend_exc == PES_EXC_ALIGN) begin
                storage_fault_cause_reg_o <= dsi_cause_i;
            end
            if (pend_exc == PES_EXC_PROGRAM) begin
                float_status_control_reg_o <= fp_cause_i;
            end
        end
    end

    // pipeline control outputs, registered
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            checkstop_o     <= 1'b0;
            hold_dispatch_o <= 1'b0;
            retire_block_o  <= 1'b0;
        end else begin
            checkstop_o     <= (state == PES_ST_STOP);
            hold_dispatch_o <= (state == PES_ST_DRAIN) || (state == PES_ST_STOP);
            retire_block_o  <= (state == PES_ST_TAKE) || (state == PES_ST_STOP);
        end
    end
endmodule

// >>> tb/pes_evt_src.sv
// far-side model: reset, event and machine-check sources
`timescale 1ns/1ps
module pes_evt_src (
    input  wire logic ref_clk_i,
    output logic [6:0] lvl_o,      // 0 soft, 1 hard, 2 ext, 3 dec, 4 smi, 5 perfmon, 6 mcheck
    output logic       tea_o,
    output logic       tea_qual_o
);
    initial begin
        lvl_o = 7'h00;
        tea_o = 1'h0;
        tea_qual_o = 1'h0;
    end

    // raise one line off the sampling edge; released lines idle low
    task automatic pulse_line(input int idx, input int cyc);
        @(negedge ref_clk_i);
        lvl_o[idx] = 1'h1;
        repeat (cyc) @(negedge ref_clk_i);
        lvl_o[idx] = 1'h0;
    endtask

    // bus error ack is a same-clock pulse, qualified or not
    task automatic tea_pulse(input logic qual);
        @(negedge ref_clk_i);
        tea_o = 1'h1;
        tea_qual_o = qual;
        @(negedge ref_clk_i);
        tea_o = 1'h0;
        tea_qual_o = 1'h0;
    endtask
endmodule

// >>> tb/pes_seq_asserts.sv
// port-level checks bound onto the sequencer
`timescale 1ns/1ps
`include "pes_defines.svh"
module pes_seq_asserts
    import pes_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    input wire logic        older_pending_i,
    input wire logic        exec_busy_i,
    input wire logic        flush_o,
    input wire logic        fetch_redirect_o,
    input wire logic [31:0] fetch_addr_o,
    input wire logic [31:0] machine_state_reg_o,
    input wire logic [3:0]  exc_type_o,
    input wire logic [1:0]  exc_class_o,
    input wire logic        checkstop_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // fixed vector of each exception type except ext, dec, smi and perfmon
    function automatic logic [19:0] vec_of(input logic [3:0] t);
        case (t)
            PES_EXC_RESET: return `PES_VEC_RESET;
            PES_EXC_MCHECK: return `PES_VEC_MCHECK;
            PES_EXC_DSI: return `PES_VEC_DSI;
            PES_EXC_ISI: return `PES_VEC_ISI;
            PES_EXC_ALIGN: return `PES_VEC_ALIGN;
            PES_EXC_PROGRAM: return `PES_VEC_PROGRAM;
            PES_EXC_FPUNAVAIL: return `PES_VEC_FPUNAVAIL;
            PES_EXC_SYSCALL: return `PES_VEC_SYSCALL;
            PES_EXC_TRACE: return `PES_VEC_TRACE;
            default: return 20'hfffff;   // others never redirect here
        endcase
    endfunction

    // legal class for a type; program alone may be imprecise
    function automatic logic cls_ok(input logic [3:0] t, input logic [1:0] c);
        case (t)
            PES_EXC_RESET, PES_EXC_MCHECK: return c == PES_CLS_ASYNC_NONMASKABLE;
            PES_EXC_EXT, PES_EXC_DEC, PES_EXC_SMI, PES_EXC_PERFMON:
                return c == PES_CLS_ASYNC_MASKABLE;
            PES_EXC_PROGRAM: return !c[1];  // either synchronous class
            default: return c == PES_CLS_SYNC_PRECISE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    redirect_with_flush_a: assert property (fetch_redirect_o == flush_o)
        else $error("redirect and flush disagree");
    one_take_pulse_a: assert property (fetch_redirect_o |=> !fetch_redirect_o [*2])
        else $error("redirects too close together");
    vector_per_type_a: assert property (fetch_redirect_o
        |-> fetch_addr_o == {12'h000, vec_of(exc_type_o)})
        else $error("wrong vector for taken type");
    supervisor_entry_a: assert property (fetch_redirect_o
        |-> !machine_state_reg_o[`PES_MST_PR])
        else $error("handler not entered in supervisor mode");
    take_clears_mce_a: assert property (fetch_redirect_o
        |-> !machine_state_reg_o[`PES_MST_MCE])
        else $error("machine check enable left set on take");
    class_by_type_a: assert property (fetch_redirect_o |-> cls_ok(exc_type_o, exc_class_o))
        else $error("class does not match type");
    drain_first_a: assert property ((older_pending_i || exec_busy_i) [*3]
        |=> !fetch_redirect_o || exc_type_o == PES_EXC_RESET)
        else $error("exception taken before drain");
    maskable_held_a: assert property (!machine_state_reg_o[`PES_MST_EE] [*4]
        |=> !(fetch_redirect_o && exc_class_o == PES_CLS_ASYNC_MASKABLE))
        else $error("maskable event taken while disabled");
    checkstop_holds_a: assert property (checkstop_o |=> checkstop_o)
        else $error("checkstop released without reset");
    checkstop_cause_a: assert property ($rose(checkstop_o)
        |-> !$past(machine_state_reg_o[`PES_MST_MCE]))
        else $error("checkstop entered with enable set");
endmodule

bind pes_sequencer pes_seq_asserts chk (
    .ref_clk_i, .rstn_i, .older_pending_i, .exec_busy_i, .flush_o, .fetch_redirect_o,
    .fetch_addr_o, .machine_state_reg_o, .exc_type_o, .exc_class_o, .checkstop_o
);

// >>> tb/testbench.sv
// self-checking bench for the exception sequencer
`timescale 1ns/1ps
`include "pes_defines.svh"
module testbench
    import pes_pkg::*;
;
    logic        ref_clk = 1'h0, rstn = 1'h0, oldest_valid = 1'h0, fp_imp = 1'h0;
    logic        older_pend = 1'h0, exec_busy = 1'h0, rfi = 1'h0, corrupt = 1'h0;
    logic [11:0] oldest_exc = 12'h000;
    logic [31:0] oldest_pc = 32'h0000_2468, dsi_cause = 32'h4200_0000;
    logic [31:0] fp_cause = 32'h8002_1000, next_pc = 32'h0000_4ac0;
    logic [6:0]  lvl;
    logic        tea_ack, tea_qual, flush, redirect, cstop;
    logic [31:0] fetch_addr, sra, srs, mst, dsr, fsr;
    logic [3:0]  etype;
    logic [1:0]  ecls;
    int          n_mismatch = 0, n_tests = 0;

    // core clock, 5 ns period
    always #2.5 ref_clk = ~ref_clk;

    pes_evt_src src (.ref_clk_i(ref_clk), .lvl_o(lvl), .tea_o(tea_ack), .tea_qual_o(tea_qual));

    pes_sequencer dut (
        .ref_clk_i(ref_clk), .rstn_i(rstn), .soft_reset_i(lvl[0]), .hard_reset_i(lvl[1]),
        .ext_int_i(lvl[2]), .dec_int_i(lvl[3]), .smi_int_i(lvl[4]), .perfmon_i(lvl[5]),
        .machine_check_input_i(lvl[6]), .transfer_error_ack_i(tea_ack),
        .tea_qualify_i(tea_qual), .oldest_valid_i(oldest_valid), .oldest_pc_i(oldest_pc),
        .oldest_exc_i(oldest_exc), .fp_imprecise_i(fp_imp), .dsi_cause_i(dsi_cause),
        .fp_cause_i(fp_cause), .older_pending_i(older_pend), .exec_busy_i(exec_busy),
        .next_pc_i(next_pc), .rfi_i(rfi), .state_corrupt_i(corrupt), .flush_o(flush),
        .fetch_redirect_o(redirect), .fetch_addr_o(fetch_addr),
        .save_restore_addr_reg_o(sra), .save_restore_state_reg_o(srs),
        .machine_state_reg_o(mst), .storage_fault_cause_reg_o(dsr),
        .float_status_control_reg_o(fsr), .exc_type_o(etype), .exc_class_o(ecls),
        .checkstop_o(cstop), .hold_dispatch_o(), .retire_block_o()
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bounded wait for a redirect, sampled 1 ns after the edge
    task automatic wait_take(input int lim, output logic got);
        got = 1'h0;
        repeat (lim) begin
            @(posedge ref_clk);
            #1;
            if (redirect === 1'h1) begin
                got = 1'h1;
                break;
            end
        end
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        rstn = 1'h0;
        repeat (10) @(negedge ref_clk);
        rstn = 1'h1;
        check("state after reset", mst, 32'h0);
    endtask

    // soft then hard reset, each vectored with saved context
    task automatic sc_reset_vec();
        logic got;
        for (int i = 0; i < 2; i++) begin
            corrupt = i[0];
            src.pulse_line(i, 1);
            wait_take(20, got);
            check("reset take", 32'(got), 32'h1);
            check("reset type", 32'(etype), 32'(PES_EXC_RESET));
            check("reset vector", fetch_addr, {12'h000, `PES_VEC_RESET});
            check("reset class", 32'(ecls), 32'(PES_CLS_ASYNC_NONMASKABLE));
            check("resume addr", sra, next_pc);
            check("saved rec", 32'(srs[`PES_MST_REC]), 32'h0);
            check("pr mce", 32'(mst[`PES_MST_PR] | mst[`PES_MST_MCE]), 32'h0);
            repeat (8) @(negedge ref_clk);
        end
        corrupt = 1'h0;
        rfi = 1'h1;
        @(negedge ref_clk);
        rfi = 1'h0;
        repeat (3) @(negedge ref_clk);
        check("ee after return", 32'(mst[`PES_MST_EE]), 32'h0);
    endtask

    // maskable events refused while the enable is clear
    task automatic sc_mask();
        logic got;
        for (int i = 2; i < 6; i++) begin
            src.pulse_line(i, 10);
            wait_take(10, got);
            check("maskable refused", 32'(got), 32'h0);
        end
    endtask

    // several conditions of one instruction, one per pass after drain
    task automatic sc_sync_order();
        pes_exc_t    seq [7] = '{PES_EXC_ISI, PES_EXC_DSI, PES_EXC_SYSCALL, PES_EXC_TRACE,
                                 PES_EXC_ALIGN, PES_EXC_PROGRAM, PES_EXC_FPUNAVAIL};
        logic [19:0] vec [7] = '{`PES_VEC_ISI, `PES_VEC_DSI, `PES_VEC_SYSCALL, `PES_VEC_TRACE,
                                 `PES_VEC_ALIGN, `PES_VEC_PROGRAM, `PES_VEC_FPUNAVAIL};
        logic        got;
        @(negedge ref_clk);
        older_pend = 1'h1;
        exec_busy = 1'h1;
        oldest_valid = 1'h1;
        oldest_exc = 12'h063;
        wait_take(20, got);
        check("take before older done", 32'(got), 32'h0);
        @(negedge ref_clk);
        older_pend = 1'h0;
        wait_take(10, got);
        check("take while executing", 32'(got), 32'h0);
        @(negedge ref_clk);
        exec_busy = 1'h0;
        for (int i = 0; i < 7; i++) begin
            if (i == 4) begin
                @(negedge ref_clk);
                oldest_exc = 12'h000;
                @(negedge ref_clk);
                oldest_exc = 12'h01c;
            end
            wait_take(40, got);
            check("sync take", 32'(got), 32'h1);
            check("sync type", 32'(etype), 32'(seq[i]));
            check("sync vector", fetch_addr, {12'h000, vec[i]});
            check("sync class", 32'(ecls), 32'(PES_CLS_SYNC_PRECISE));
            check("saved addr", sra, oldest_pc);
            if (seq[i] == PES_EXC_DSI) begin
                check("storage cause", dsr, dsi_cause);
            end
        end
        @(negedge ref_clk);
        oldest_exc = 12'h000;
        oldest_valid = 1'h0;
        wait_take(20, got);
        check("extra take", 32'(got), 32'h0);
    endtask

    // floating imprecise is the one synchronous imprecise class
    task automatic sc_fp();
        logic got;
        @(negedge ref_clk);
        fp_imp = 1'h1;
        oldest_valid = 1'h1;
        wait_take(40, got);
        @(negedge ref_clk);
        fp_imp = 1'h0;
        oldest_valid = 1'h0;
        check("fp take", 32'(got), 32'h1);
        check("fp type", 32'(etype), 32'(PES_EXC_PROGRAM));
        check("fp class", 32'(ecls), 32'(PES_CLS_SYNC_IMPRECISE));
        check("fp cause", fsr, fp_cause);
    endtask

    // enable clear: a machine check ends in checkstop, never a vector
    task automatic sc_mcheck();
        logic got;
        src.tea_pulse(1'h0);
        wait_take(10, got);
        check("unqualified error", 32'(cstop), 32'h0);
        src.pulse_line(6, 1);
        wait_take(10, got);
        check("mcheck no vector", 32'(got), 32'h0);
        check("mcheck checkstop", 32'(cstop), 32'h1);
        do_reset();
        check("checkstop cleared", 32'(cstop), 32'h0);
        src.tea_pulse(1'h1);
        wait_take(10, got);
        check("qualified error", 32'(cstop), 32'h1);
        do_reset();
    endtask

    // main sequence
    initial begin
        do_reset();
        sc_reset_vec();
        sc_mask();
        sc_sync_order();
        sc_fp();
        sc_mcheck();
        final_report();
    end

    // watchdog, far beyond the ~300 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        final_report();
    end
endmodule
